/* verilog/fri_pkg.sv */
// constants, types and helpers shared by the flash read interface
package fri_pkg;

   // ******************************************************************
   // register byte addresses
   // ******************************************************************
   localparam logic [31:0] FRI_CLK_EN_ADDR = 32'h4000402C;
   localparam logic [31:0] FRI_CLK_STAT_ADDR = 32'h40004030;
   localparam logic [31:0] FRI_ACR_ADDR = 32'h40008000;
   localparam logic [31:0] FRI_KEY_ADDR = 32'h40008004;
   localparam logic [31:0] FRI_OPTKEY_ADDR = 32'h40008008;
   localparam logic [31:0] FRI_STAT_ADDR = 32'h4000800C;
   localparam logic [31:0] FRI_CTRL_ADDR = 32'h40008010;
   localparam logic [31:0] FRI_TADDR_ADDR = 32'h40008014;
   localparam logic [31:0] FRI_RSVD_ADDR = 32'h40008018;
   localparam logic [31:0] FRI_OBV_ADDR = 32'h4000801C;
   localparam logic [31:0] FRI_WPV_ADDR = 32'h40008020;

   // ******************************************************************
   // field positions and reset values
   // ******************************************************************
   localparam int FRI_ACR_LAT_LSB = 0;
   localparam int FRI_ACR_LAT_W = 3;
   localparam int FRI_ACR_CACHE_BIT = 4;
   localparam int FRI_CLK_EN_BIT = 0;
   localparam int FRI_CLK_RDY_BIT = 0;
   localparam int FRI_STAT_BUSY_BIT = 0;
   localparam logic [FRI_ACR_LAT_W-1:0] FRI_LAT_RESET = 3'h0;
   localparam logic FRI_CACHE_RESET = 1'b0;
   localparam logic FRI_CLK_EN_RESET = 1'b0;

   // ******************************************************************
   // flash regions
   // ******************************************************************
   localparam logic [31:0] FRI_MAIN_BASE = 32'h08000000;
   localparam int FRI_PAGE_BYTES = 2048;
   localparam int FRI_PAGE_COUNT = 128;
   localparam logic [31:0] FRI_MAIN_LAST = 32'h0803FFFF;
   localparam logic [31:0] FRI_SYS_BASE = 32'h08040000;
   localparam logic [31:0] FRI_SYS_LAST = 32'h080407FF;
   localparam logic [31:0] FRI_OPT_BASE = 32'h08040800;
   localparam logic [31:0] FRI_OPT_LAST = 32'h0804080F;
   localparam logic [31:0] FRI_CUST_BASE = 32'h08040810;
   localparam logic [31:0] FRI_CUST_LAST = 32'h08040FFF;
   localparam logic [31:0] FRI_EXT_BASE = 32'h08041000;
   localparam logic [31:0] FRI_EXT_LAST = 32'h08044FFF;

   // ******************************************************************
   // bus encodings and states
   // ******************************************************************
   localparam logic FRI_HRESP_OKAY = 1'b0;
   localparam logic FRI_HRESP_ERROR = 1'b1;
   localparam int FRI_TAG_W = 29;

   typedef enum logic [1:0] {PORT_IDLE, PORT_WAIT, PORT_ERR} fri_port_state_e;
   typedef enum logic {ARR_IDLE, ARR_READ} fri_arr_state_e;

   // address lies in main array or information block
   function automatic logic fri_in_flash(input logic [31:0] addr);
      fri_in_flash = ((addr >= FRI_MAIN_BASE) && (addr <= FRI_MAIN_LAST)) ||
                     ((addr >= FRI_SYS_BASE) && (addr <= FRI_EXT_LAST));
   endfunction : fri_in_flash

endpackage : fri_pkg

/* verilog/fri_cache_line.sv */
// single direct mapped prefetch line
`timescale 1ns/100ps
module fri_cache_line (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic fill,
   input wire logic [fri_pkg::FRI_TAG_W-1:0] fillTag,
   input wire logic [63:0] fillLine,
   input wire logic invalidate,
   output logic lineValid,
   output logic [fri_pkg::FRI_TAG_W-1:0] lineTag,
   output logic [63:0] lineData
);
   import fri_pkg::*;

   // valid flag, invalidate wins over a fill
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lineValid <= 1'b0;
      end else if (clkEn) begin
         if (invalidate) begin
            lineValid <= 1'b0;
         end else if (fill) begin
            lineValid <= 1'b1;
         end
      end
   end

   // tag and both instruction words of the line
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lineTag <= '0;
         lineData <= 64'h0000000000000000;
      end else if (clkEn && fill) begin
         lineTag <= fillTag;
         lineData <= fillLine;
      end
   end

endmodule : fri_cache_line

/* verilog/fri_ahb_port.sv */
// read only bus slave port with registered response
`timescale 1ns/100ps
module fri_ahb_port (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic lowPower,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] haddr,
   input wire logic hready,
   output logic hreadyOut,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic reqPending,
   output logic [31:0] reqAddr,
   input wire logic done,
   input wire logic [31:0] doneData,
   input wire logic abort
);
   import fri_pkg::*;

   fri_port_state_e state_reg;
   logic accept;

   // address phase of an active transfer
   assign accept = hsel && htrans[1] && hready;
   assign reqPending = (state_reg == PORT_WAIT);

   // transfer sequencing and response
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= PORT_IDLE;
         hreadyOut <= 1'b1;
         hresp <= FRI_HRESP_OKAY;
         hrdata <= 32'h00000000;
         reqAddr <= 32'h00000000;
      end else if (clkEn) begin
         case (state_reg)
            PORT_IDLE: begin
               hresp <= FRI_HRESP_OKAY;
               hreadyOut <= 1'b1;
               if (accept) begin
                  reqAddr <= haddr;
                  hreadyOut <= 1'b0;
                  if (hwrite || lowPower || !fri_in_flash(haddr)) begin
                     hresp <= FRI_HRESP_ERROR;
                     state_reg <= PORT_ERR;
                  end else begin
                     state_reg <= PORT_WAIT;
                  end
               end
            end
            PORT_WAIT: begin
               if (abort) begin
                  hresp <= FRI_HRESP_ERROR;
                  state_reg <= PORT_ERR;
               end else if (done) begin
                  hrdata <= doneData;
                  hreadyOut <= 1'b1;
                  state_reg <= PORT_IDLE;
               end
            end
            PORT_ERR: begin
               hreadyOut <= 1'b1; // second error cycle
               state_reg <= PORT_IDLE;
            end
            default: begin
               state_reg <= PORT_IDLE;
            end
         endcase
      end
   end

endmodule : fri_ahb_port

/* verilog/fri_top.sv */
// flash read interface: two read ports, prefetch line, arbiter, registers
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
module fri_top (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic iHsel,
   input wire logic [1:0] iHtrans,
   input wire logic iHwrite,
   input wire logic [31:0] iHaddr,
   input wire logic iHready,
   output logic iHreadyOut,
   output logic [31:0] iHrdata,
   output logic iHresp,
   input wire logic dHsel,
   input wire logic [1:0] dHtrans,
   input wire logic dHwrite,
   input wire logic [31:0] dHaddr,
   input wire logic dHready,
   output logic dHreadyOut,
   output logic [31:0] dHrdata,
   output logic dHresp,
   output logic [fri_pkg::FRI_TAG_W-1:0] arrAddr,
   output logic arrRead,
   input wire logic [63:0] arrData,
   input wire logic pgmBusy,
   input wire logic lowPower,
   output logic ctlClkEnable,
   input wire logic ctlClkAck
);
   import fri_pkg::*;
   // two bus ports, one array sequencer
   // data port wins ties with fetches
   // hits answered from the line alone

   // ******************************************************************
   // declarations
   // ******************************************************************
   // register bus state
   logic [FRI_ACR_LAT_W-1:0] lat_reg;
   logic cacheEn_reg;
   logic ackMeta_reg;
   logic ackSync_reg;
   logic [31:0] rdMux;
   logic [31:0] acrValue;
   logic mapped;
   logic apbSetup;
   logic apbWrite;

   // port requests and completions
   logic iPending;
   logic dPending;
   logic [31:0] iReqAddr;
   logic [31:0] dReqAddr;
   logic iDone;
   logic dDone;
   logic [31:0] iDoneData;
   logic [31:0] dDoneData;
   logic iAbort;
   logic dAbort;

   // sequencer and arbiter
   fri_arr_state_e arrState_reg;
   logic [FRI_ACR_LAT_W-1:0] cnt_reg;
   logic ownerData_reg;
   logic canServe;
   logic grantD;
   logic grantI;
   logic arrDone;
   logic hit;
   logic iHit;

   // prefetch line view
   logic lineValid;
   logic [FRI_TAG_W-1:0] lineTag;
   logic [63:0] lineData;
   logic fill;
   logic invalidate;

   // ******************************************************************
   // register bus slave
   // ******************************************************************

   // writes commit only at the ready edge
   // setup and committing access phases
   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pready && pwrite && mapped;

   // reserved bits read as zero
   // access control word as software sees it
   always_comb begin
      acrValue = 32'h00000000;
      acrValue[FRI_ACR_LAT_LSB +: FRI_ACR_LAT_W] = lat_reg;
      acrValue[FRI_ACR_CACHE_BIT] = cacheEn_reg;
   end

   // unmapped addresses read zero with error
   // read mux and address decode
   always_comb begin
      rdMux = 32'h00000000;
      mapped = 1'b1;
      case (paddr)
         FRI_CLK_EN_ADDR: begin
            rdMux[FRI_CLK_EN_BIT] = ctlClkEnable;
         end
         FRI_CLK_STAT_ADDR: begin
            rdMux[FRI_CLK_RDY_BIT] = ackSync_reg;
         end
         FRI_ACR_ADDR: begin
            rdMux = acrValue;
         end
         FRI_STAT_ADDR: begin
            rdMux[FRI_STAT_BUSY_BIT] = pgmBusy;
         end
         FRI_KEY_ADDR, FRI_OPTKEY_ADDR, FRI_CTRL_ADDR, FRI_TADDR_ADDR,
         FRI_RSVD_ADDR, FRI_OBV_ADDR, FRI_WPV_ADDR: begin
            rdMux = 32'h00000000; // handled by the program/erase side
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // registered answer keeps pready off the
   // address decode path; adds no wait state
   // no wait state: answer registered during setup
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready <= apbSetup;
         if (apbSetup) begin
            prdata <= pwrite ? 32'h00000000 : rdMux;
            pslverr <= !mapped;
         end
      end
   end

   // latency change takes effect at the
   // next array read or busy restart, not otherwise mid-read
   // access control register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lat_reg <= FRI_LAT_RESET;
         cacheEn_reg <= FRI_CACHE_RESET;
      end else if (clkEn && apbWrite && (paddr == FRI_ACR_ADDR)) begin
         lat_reg <= pwdata[FRI_ACR_LAT_LSB +: FRI_ACR_LAT_W];
         cacheEn_reg <= pwdata[FRI_ACR_CACHE_BIT];
      end
   end

   // bit 0 gates the program/erase clock
   // controller clock enable register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctlClkEnable <= FRI_CLK_EN_RESET;
      end else if (clkEn && apbWrite && (paddr == FRI_CLK_EN_ADDR)) begin
         ctlClkEnable <= pwdata[FRI_CLK_EN_BIT];
      end
   end

   // status bit lags the acknowledge by one
   // or two cycles; software polls it
   // clock ready acknowledge comes from another domain
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ackMeta_reg <= 1'b0;
         ackSync_reg <= 1'b0;
      end else if (clkEn) begin
         ackMeta_reg <= ctlClkAck;
         ackSync_reg <= ackMeta_reg;
      end
   end

   // ******************************************************************
   // processor facing read ports
   // ******************************************************************

   // both ports are the same slave; only
   // the completion strobes differ
   // instruction fetch port
   fri_ahb_port u_iport (
      .mclk(mclk),
      .nrst(nrst),
      .clkEn(clkEn),
      .lowPower(lowPower),
      .hsel(iHsel),
      .htrans(iHtrans),
      .hwrite(iHwrite),
      .haddr(iHaddr),
      .hready(iHready),
      .hreadyOut(iHreadyOut),
      .hrdata(iHrdata),
      .hresp(iHresp),
      .reqPending(iPending),
      .reqAddr(iReqAddr),
      .done(iDone),
      .doneData(iDoneData),
      .abort(iAbort)
   );

   // literal and constant loads, no line
   // literal and data port
   fri_ahb_port u_dport (
      .mclk(mclk),
      .nrst(nrst),
      .clkEn(clkEn),
      .lowPower(lowPower),
      .hsel(dHsel),
      .htrans(dHtrans),
      .hwrite(dHwrite),
      .haddr(dHaddr),
      .hready(dHready),
      .hreadyOut(dHreadyOut),
      .hrdata(dHrdata),
      .hresp(dHresp),
      .reqPending(dPending),
      .reqAddr(dReqAddr),
      .done(dDone),
      .doneData(dDoneData),
      .abort(dAbort)
   );

   // ******************************************************************
   // prefetch line
   // ******************************************************************

   // tag is the line address, bits 31 to 3
   // a stale tag after disable never hits
   // hit needs an enabled, valid line with matching tag
   assign hit = cacheEn_reg && lineValid && (lineTag == iReqAddr[31:3]);
   assign iHit = hit && iPending && canServe;

   // data reads must not disturb the line
   // program/erase may change the array under it
   // refill on instruction array reads only, drop line when stale
   assign fill = arrDone && !ownerData_reg && cacheEn_reg;
   assign invalidate = !cacheEn_reg || pgmBusy;

   fri_cache_line u_line (
      .mclk(mclk),
      .nrst(nrst),
      .clkEn(clkEn),
      .fill(fill),
      .fillTag(iReqAddr[31:3]),
      .fillLine(arrData),
      .invalidate(invalidate),
      .lineValid(lineValid),
      .lineTag(lineTag),
      .lineData(lineData)
   );

   // ******************************************************************
   // arbiter and array sequencer
   // ******************************************************************

   // stalled reads keep ready low and wait
   // rather than return stale array data
   // nothing is served during program/erase or low power
   assign canServe = !pgmBusy && !lowPower;

   // an in-flight read is never preempted
   // data port first, instruction port only on a miss
   assign grantD = (arrState_reg == ARR_IDLE) && canServe && dPending;
   assign grantI = (arrState_reg == ARR_IDLE) && canServe && !dPending &&
                   iPending && !hit;

   // last held cycle of an array read
   assign arrDone = (arrState_reg == ARR_READ) && (cnt_reg == '0) && canServe;

   // abort turns into a two-cycle error
   // pending requests dropped in low power
   assign iAbort = lowPower && iPending;
   assign dAbort = lowPower && dPending;

   // address bit 2 picks the word of the line
   // completion strobes and word selection within the line
   assign dDone = arrDone && ownerData_reg;
   assign iDone = (arrDone && !ownerData_reg) || iHit;
   assign dDoneData = dReqAddr[2] ? arrData[63:32] : arrData[31:0];
   always_comb begin
      if (arrDone && !ownerData_reg) begin
         iDoneData = iReqAddr[2] ? arrData[63:32] : arrData[31:0];
      end else begin
         iDoneData = iReqAddr[2] ? lineData[63:32] : lineData[31:0];
      end
   end

   // zero latency gives a one-cycle strobe
   // busy restarts the count so the array
   // sees a full hold after the operation
   // array read controls held for latency plus one cycles
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         arrState_reg <= ARR_IDLE;
         arrRead <= 1'b0;
         arrAddr <= '0;
         cnt_reg <= FRI_LAT_RESET;
         ownerData_reg <= 1'b0;
      end else if (clkEn) begin
         case (arrState_reg)
            ARR_IDLE: begin
               if (grantD || grantI) begin
                  arrRead <= 1'b1;
                  arrAddr <= grantD ? dReqAddr[31:3] : iReqAddr[31:3];
                  cnt_reg <= lat_reg;
                  ownerData_reg <= grantD;
                  arrState_reg <= ARR_READ;
               end
            end
            ARR_READ: begin
               if (lowPower) begin
                  arrRead <= 1'b0;
                  arrState_reg <= ARR_IDLE;
               end else if (pgmBusy) begin
                  cnt_reg <= lat_reg; // restart once idle
               end else if (cnt_reg == '0) begin
                  arrRead <= 1'b0;
                  arrState_reg <= ARR_IDLE;
               end else begin
                  cnt_reg <= FRI_ACR_LAT_W'(cnt_reg - 1'b1);
               end
            end
            default: begin
               arrState_reg <= ARR_IDLE;
            end
         endcase
      end
   end

endmodule : fri_top

/* sim/fri_flash_model.sv */
// behavioural flash array that answers line reads, slowly when asked
`timescale 1ns/100ps
module fri_flash_model (
   input wire logic mclk,
   input wire logic [fri_pkg::FRI_TAG_W-1:0] arrAddr,
   input wire logic arrRead,
   input wire logic [3:0] settle,
   output logic [63:0] arrData
);
   import fri_pkg::*;
   logic [63:0] junk = 64'hF0E1D2C3B4A59687;
   logic [3:0] held = 4'h0;
   logic [FRI_TAG_W-1:0] lastAddr = '0;
   wire [3:0] soFar = (arrAddr == lastAddr) ? held : 4'h0;

   // moving pattern so an early or late sample never looks right
   always_ff @(posedge mclk) begin
      junk <= {junk[62:0], ~junk[63]};
      lastAddr <= arrAddr;
      held <= !arrRead ? 4'h0 : (soFar == 4'hF) ? soFar : soFar + 4'h1;
   end

   // two 32-bit cells per line, valid only from the settle-th strobe cycle on
   assign arrData = (arrRead && soFar + 4'h1 >= settle) ?
      {{arrAddr, 3'h4} ^ 32'h5A5A5A5A, {arrAddr, 3'h0} ^ 32'h5A5A5A5A} : junk;
endmodule : fri_flash_model

/* sim/fri_top_chk.sv */
// port checker for the flash read interface
`timescale 1ns/100ps
module fri_top_chk (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic iHsel,
   input wire logic [1:0] iHtrans,
   input wire logic iHready,
   input wire logic iHreadyOut,
   input wire logic iHresp,
   input wire logic dHsel,
   input wire logic [1:0] dHtrans,
   input wire logic dHwrite,
   input wire logic [31:0] dHaddr,
   input wire logic dHready,
   input wire logic dHreadyOut,
   input wire logic dHresp,
   input wire logic [fri_pkg::FRI_TAG_W-1:0] arrAddr,
   input wire logic arrRead,
   input wire logic pgmBusy,
   input wire logic lowPower,
   input wire logic ctlClkEnable
);
   import fri_pkg::*;
   logic [2:0] accLat;
   logic accCache;
   logic [3:0] runLen;
   logic runOdd;
   wire iTake = iHsel && iHtrans[1] && iHready;
   wire dTake = dHsel && dHtrans[1] && dHready;
   wire acrWr = psel && penable && pready && pwrite && paddr == FRI_ACR_ADDR;

   // shadow of the access control word
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         accLat <= 3'h0;
         accCache <= 1'h0;
      end else if (acrWr) begin
         accLat <= pwdata[2:0];
         accCache <= pwdata[4];
      end
   end

   // strobe run length, marked when busy or low power cut in
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         runLen <= 4'h0;
         runOdd <= 1'h0;
      end else begin
         runLen <= arrRead ? runLen + 4'h1 : 4'h0;
         runOdd <= arrRead && (runOdd || pgmBusy || lowPower);
      end
   end

   // ******************************************************************
   // assertions
   // ******************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence errResp(r, e);
      !r && e ##1 r && e;
   endsequence

   apb_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("register access not answered in one cycle");
   clk_enable_a: assert property (psel && penable && pready && pwrite &&
      paddr == FRI_CLK_EN_ADDR |=> ctlClkEnable == $past(pwdata[0]))
      else $error("controller clock enable not following write");
   take_stall_a: assert property (iTake |=> !iHreadyOut)
      else $error("instruction take not stalled");
   lowpwr_err_a: assert property (lowPower && iTake |=> errResp(iHreadyOut, iHresp))
      else $error("fetch in low power not aborted");
   write_err_a: assert property (dTake && dHwrite |=> errResp(dHreadyOut, dHresp))
      else $error("write on data port not refused");
   busy_stall_a: assert property (pgmBusy && !dHreadyOut && !dHresp |=> !dHreadyOut)
      else $error("data read finished while busy");
   strobe_hold_a: assert property ($fell(arrRead) && !runOdd |->
      runLen == {1'h0, accLat} + 4'h1)
      else $error("array strobe length differs from latency");
   data_first_a: assert property (dTake && iTake && !dHwrite && !lowPower &&
      !pgmBusy && !arrRead && !accCache |-> ##2
      arrRead && {arrAddr, 3'h0} == ($past(dHaddr, 2) & 32'hFFFFFFF8))
      else $error("data port not served first");
endmodule : fri_top_chk

bind fri_top fri_top_chk chk (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .iHsel, .iHtrans, .iHready, .iHreadyOut, .iHresp, .dHsel, .dHtrans, .dHwrite,
   .dHaddr, .dHready, .dHreadyOut, .dHresp, .arrAddr, .arrRead, .pgmBusy, .lowPower,
   .ctlClkEnable);

/* sim/fri_tb_top.sv */
// self-checking bench for the flash read interface
`timescale 1ns/100ps
module fri_tb_top;
   import fri_pkg::*;
   typedef struct {int k; logic [31:0] a; logic [31:0] v; logic e; int nr;} fri_row_s;
   logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic pgmBusy = 0, lowPower = 0, ctlClkAck = 0, prevRd = 0;
   logic [31:0] paddr = 0, pwdata = 0, rd, rd2;
   logic [31:0] hAd [2] = '{0, 0};
   logic [1:0] hSel = 0, hWr = 0;
   logic [3:0] settle = 4'h1;
   logic er, er2;
   wire [1:0] hRdy, hErr;
   wire [31:0] hRd [2];
   wire [31:0] prdata;
   wire pready, pslverr, arrRead, ctlClkEnable;
   wire [63:0] arrData;
   wire [FRI_TAG_W-1:0] arrAddr;
   int mismatches = 0, checked = 0, cycles = 0, reads = 0, n0, tI, tD;
   fri_row_s r;
   // kinds: 0 register write, 1 register read, 2 fetch, 3 data read, 4 data write
   fri_row_s rows[] = '{
      '{1, FRI_ACR_ADDR, 0, 0, 0}, '{1, FRI_CLK_EN_ADDR, 0, 0, 0},
      '{1, FRI_KEY_ADDR, 0, 0, 0}, '{1, FRI_RSVD_ADDR, 0, 0, 0},
      '{1, 32'h40008024, 0, 1, 0}, '{3, FRI_MAIN_BASE, 0, 0, 1},
      '{3, 32'h0803FFFC, 0, 0, 1}, '{3, FRI_OPT_BASE, 0, 0, 1},
      '{3, FRI_CUST_BASE, 0, 0, 1}, '{3, 32'h08040FFC, 0, 0, 1},
      '{3, 32'h08045000, 0, 1, 0}, '{3, 32'h07FFFFFC, 0, 1, 0},
      '{4, FRI_SYS_BASE, 0, 1, 0}, '{2, 32'h08000200, 0, 0, 1},
      '{2, 32'h08000204, 0, 0, 1}, '{0, FRI_ACR_ADDR, 32'h10, 0, 0},
      '{1, FRI_ACR_ADDR, 32'h10, 0, 0}, '{2, 32'h08000200, 0, 0, 1},
      '{2, 32'h08000204, 0, 0, 0}, '{2, 32'h08000200, 0, 0, 0},
      '{3, 32'h08000204, 0, 0, 1}, '{2, 32'h08000208, 0, 0, 1},
      '{2, 32'h08000200, 0, 0, 1}, '{0, FRI_ACR_ADDR, 32'hFFFFFFFB, 0, 0},
      '{1, FRI_ACR_ADDR, 32'h13, 0, 0}, '{2, 32'h08000300, 0, 0, 1},
      '{3, 32'h08000300, 0, 0, 1}, '{0, FRI_ACR_ADDR, 32'h0, 0, 0}};

   fri_top dut (.mclk, .nrst, .clkEn(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .iHsel(hSel[0]), .iHtrans({hSel[0], 1'h0}),
      .iHwrite(hWr[0]), .iHaddr(hAd[0]), .iHready(hRdy[0]), .iHreadyOut(hRdy[0]),
      .iHrdata(hRd[0]), .iHresp(hErr[0]), .dHsel(hSel[1]), .dHtrans({hSel[1], 1'h0}),
      .dHwrite(hWr[1]), .dHaddr(hAd[1]), .dHready(hRdy[1]), .dHreadyOut(hRdy[1]),
      .dHrdata(hRd[1]), .dHresp(hErr[1]), .arrAddr, .arrRead, .arrData, .pgmBusy,
      .lowPower, .ctlClkEnable, .ctlClkAck);
   fri_flash_model array (.mclk, .arrAddr, .arrRead, .settle, .arrData);

   always #2 mclk = ~mclk;

   // controller clock answers a cycle later; array starts and timeout
   always @(posedge mclk) begin
      ctlClkAck <= ctlClkEnable;
      prevRd <= arrRead;
      if (arrRead && !prevRd) reads++;
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end

   function automatic logic [31:0] fw(input logic [31:0] a);
      return {a[31:2], 2'h0} ^ 32'h5A5A5A5A;
   endfunction : fw

   task automatic cmpWord(input logic [31:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : cmpWord

   task automatic cmpCount(input int got, exp, input string what);
      checked++;
      if (got != exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %0d want %0d", $time, what, got, exp);
      end
   endtask : cmpCount

   task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] q,
      output logic e);
      @(posedge mclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do begin @(posedge mclk); end while (pready !== 1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task automatic ahb(input int p, input logic wr, input logic [31:0] a,
      output logic [31:0] q, output logic e);
      @(posedge mclk);
      hSel[p] <= 1;
      hWr[p] <= wr;
      hAd[p] <= a;
      do begin @(posedge mclk); end while (hRdy[p] !== 1);
      hSel[p] <= 0;
      do begin @(posedge mclk); end while (hRdy[p] !== 1);
      q = hRd[p];
      e = hErr[p];
   endtask : ahb

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude

   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1;
      foreach (rows[i]) begin
         r = rows[i];
         n0 = reads;
         if (r.k < 2) apb(r.k == 0, r.a, r.v, rd, er);
         else ahb(r.k == 2 ? 0 : 1, r.k == 4, r.a, rd, er);
         if (r.k > 1) r.v = fw(r.a);
         if (r.k != 0) cmpWord({31'h0, er}, {31'h0, r.e}, "error");
         if (r.k == 1 || (r.k > 1 && !r.e)) cmpWord(rd, r.v, "data");
         cmpCount(reads - n0, r.nr, "array reads");
      end
      // controller clock handshake
      apb(1, FRI_CLK_EN_ADDR, 1, rd, er);
      for (int i = 0; i < 8 && !rd[0]; i++) apb(0, FRI_CLK_STAT_ADDR, 0, rd, er);
      cmpWord(rd & 1, 1, "clock ready");
      // read held off by a busy controller
      pgmBusy <= 1;
      apb(0, FRI_STAT_ADDR, 0, rd, er);
      cmpWord(rd & 1, 1, "busy flag");
      fork
         ahb(1, 0, 32'h08000010, rd, er);
         begin
            repeat (20) @(posedge mclk);
            cmpWord({31'h0, hRdy[1]}, 0, "stalled");
            pgmBusy <= 0;
         end
      join
      cmpWord(rd, fw(32'h08000010), "after busy");
      // both ports at once
      fork
         begin ahb(0, 0, 32'h08000500, rd, er); tI = cycles; end
         begin ahb(1, 0, 32'h08000600, rd2, er2); tD = cycles; end
      join
      cmpCount(int'(tD < tI), 1, "data first");
      cmpWord(rd ^ rd2, fw(32'h08000500) ^ fw(32'h08000600), "both data");
      // slow array with longest hold, then low power abort
      apb(1, FRI_ACR_ADDR, 32'h7, rd, er);
      settle <= 4'h8;
      ahb(1, 0, 32'h08000700, rd, er);
      cmpWord(rd, fw(32'h08000700), "slow array");
      fork
         ahb(1, 0, 32'h08000708, rd, er);
         begin repeat (3) @(posedge mclk); lowPower <= 1; end
      join
      cmpWord({31'h0, er}, 1, "abort waiting");
      ahb(0, 0, 32'h08000800, rd, er);
      cmpWord({31'h0, er}, 1, "abort at take");
      lowPower <= 0;
      // reset in mid run
      nrst <= 0;
      repeat (2) @(posedge mclk);
      nrst <= 1;
      apb(0, FRI_ACR_ADDR, 0, rd, er);
      cmpWord(rd, 0, "latency after reset");
      conclude();
   end
endmodule : fri_tb_top
